// [hdl/ppc_pid_top.sv]
// Purpose: Process PID regulator commanding motor frequency
// Assumes: Inputs synchronous to clk; analog codes span 0..10 V
// Notes:   Registers over a plain strobe port, read data next cycle
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_pid_top
#(
	parameter int AI_W       = 12,
	parameter int SAMPLE_CYC = `PPC_SAMPLE_NS / `PPC_CLK_NS,
	parameter int GATE_CYC   = `PPC_GATE_MS * (`PPC_SAMPLE_NS / `PPC_CLK_NS)
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// Register port
	input  wire logic [7:0]       addr,
	input  wire logic [31:0]      wdata,
	input  wire logic             wr,
	input  wire logic             rd,
	output logic      [31:0]      rdata,
	// Process inputs
	input  wire logic [AI_W-1:0]  first_analog_input,
	input  wire logic [AI_W-1:0]  second_analog_input,
	input  wire logic             pulse_in,
	input  wire logic [13:0]      freq_cmd_pct,
	input  wire logic             run,
	// Results
	output logic      [13:0]      freq_out_pct,
	output logic                  same_source_config_alarm,
	output logic                  irq
);

	localparam int AI_MAX = (1 << AI_W) - 1;

	// ----------------------------------------
	// Settings and status state
	// ----------------------------------------
	logic [2:0]  tsrc_ff,  nxt_tsrc;
	logic [1:0]  fsrc_ff,  nxt_fsrc;
	logic [13:0] store_ff, nxt_store;
	logic [3:0]  mode_ff,  nxt_mode;
	logic [9:0]  fbg_ff,   nxt_fbg;
	logic [9:0]  kp_ff,    nxt_kp;
	logic [9:0]  ti_ff,    nxt_ti;
	logic [9:0]  td_ff,    nxt_td;
	logic [2:0]  msel_ff,  nxt_msel;
	logic [15:0] fbmax_ff, nxt_fbmax;
	logic [3:0]  dec_ff,   nxt_dec;
	logic [3:0]  unit_ff,  nxt_unit;
	logic [15:0] pscl_ff,  nxt_pscl;
	logic [3:0]  pflt_ff,  nxt_pflt;
	logic [1:0]  stat_ff,  nxt_stat;
	logic [1:0]  ien_ff,   nxt_ien;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        alarm_ff, nxt_alarm;
	logic [13:0] fout_ff,  nxt_fout;
	logic [13:0] base_ff,  nxt_base;
	logic        run_d_ff, nxt_run_d;
	logic [31:0] scnt_ff,  nxt_scnt;
	logic [31:0] gcnt_ff,  nxt_gcnt;
	logic [31:0] pcnt_ff,  nxt_pcnt;
	logic        pin_d_ff, nxt_pin_d;
	logic [13:0] pflt_v_ff, nxt_pflt_v;

	logic [13:0] target, fb_raw, ai1_pct, ai2_pct, disp;
	logic [1:0]  ev;

	ppc_core_if cif ();

	function automatic logic [13:0] ana_pct(input logic [AI_W-1:0] code);
		logic [31:0] p;
		p = (32'(code) * `PPC_PCT_FULL) / AI_MAX;
		return p[13:0];
	endfunction

	assign ai1_pct = ana_pct(first_analog_input);
	assign ai2_pct = ana_pct(second_analog_input);

	// ----------------------------------------
	// Target and feedback selection
	// ----------------------------------------
	always_comb
	begin
		logic [31:0] dv;
		target = store_ff;
		if (msel_ff == `PPC_MAIN_SEL_PID)
		begin
			unique case (ppc_pkg::ppc_tsrc_t'(tsrc_ff))
				ppc_pkg::PPC_TS_AI1:    target = ai1_pct;
				ppc_pkg::PPC_TS_AI2:    target = ai2_pct;
				ppc_pkg::PPC_TS_PULSE:  target = pflt_v_ff;
				ppc_pkg::PPC_TS_STORED: target = store_ff;
				ppc_pkg::PPC_TS_FCMD:   target = freq_cmd_pct;
				default:                target = store_ff;
			endcase
		end
		fb_raw = (fsrc_ff == 2'h2) ? second_analog_input_pct() : ai1_pct;
		dv = (32'(store_ff) * 32'(fbmax_ff)) / `PPC_PCT_FULL;
		disp = (dv > 32'(fbmax_ff)) ? fbmax_ff[13:0] : dv[13:0];
	end

	function automatic logic [13:0] second_analog_input_pct();
		return ai2_pct;
	endfunction

	assign ev[`PPC_I_ALARM] = nxt_alarm & ~alarm_ff;
	assign ev[`PPC_I_CLAMP] = cif.clamp_hit;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic [31:0] hz, pct;
		nxt_tsrc  = tsrc_ff;
		nxt_fsrc  = fsrc_ff;
		nxt_store = store_ff;
		nxt_mode  = mode_ff;
		nxt_fbg   = fbg_ff;
		nxt_kp    = kp_ff;
		nxt_ti    = ti_ff;
		nxt_td    = td_ff;
		nxt_msel  = msel_ff;
		nxt_fbmax = fbmax_ff;
		nxt_dec   = dec_ff;
		nxt_unit  = unit_ff;
		nxt_pscl  = pscl_ff;
		nxt_pflt  = pflt_ff;
		nxt_ien   = ien_ff;
		nxt_stat  = stat_ff;
		if (wr)
		begin
			unique case (addr)
				`PPC_A_TGT_SRC:   nxt_tsrc  = wdata[2:0];
				`PPC_A_FB_SRC:    nxt_fsrc  = wdata[1:0];
				`PPC_A_TGT_STORE: nxt_store = wdata[13:0];
				`PPC_A_MODE:      nxt_mode  = wdata[3:0];
				`PPC_A_FB_GAIN:   nxt_fbg   = wdata[9:0];
				`PPC_A_KP:        nxt_kp    = wdata[9:0];
				`PPC_A_TI:        nxt_ti    = wdata[9:0];
				`PPC_A_TD:        nxt_td    = wdata[9:0];
				`PPC_A_MAIN_SEL:  nxt_msel  = wdata[2:0];
				`PPC_A_FB_MAX:    nxt_fbmax = wdata[15:0];
				`PPC_A_DECIMALS:  nxt_dec   = wdata[3:0];
				`PPC_A_UNIT:      nxt_unit  = wdata[3:0];
				`PPC_A_PLS_SCALE: nxt_pscl  = wdata[15:0];
				`PPC_A_PLS_FILT:  nxt_pflt  = wdata[3:0];
				`PPC_A_INT_CLR:   nxt_stat  = stat_ff & ~wdata[1:0];
				`PPC_A_INT_EN:    nxt_ien   = wdata[1:0];
				default:          ;
			endcase
		end
		// Event beats a clear in the same cycle
		nxt_stat = nxt_stat | ev;
		nxt_rdata = '0;
		if (rd)
		begin
			unique case (addr)
				`PPC_A_TGT_SRC:   nxt_rdata = 32'(tsrc_ff);
				`PPC_A_FB_SRC:    nxt_rdata = 32'(fsrc_ff);
				`PPC_A_TGT_STORE: nxt_rdata = 32'(store_ff);
				`PPC_A_MODE:      nxt_rdata = 32'(mode_ff);
				`PPC_A_FB_GAIN:   nxt_rdata = 32'(fbg_ff);
				`PPC_A_KP:        nxt_rdata = 32'(kp_ff);
				`PPC_A_TI:        nxt_rdata = 32'(ti_ff);
				`PPC_A_TD:        nxt_rdata = 32'(td_ff);
				`PPC_A_MAIN_SEL:  nxt_rdata = 32'(msel_ff);
				`PPC_A_FB_MAX:    nxt_rdata = 32'(fbmax_ff);
				`PPC_A_DECIMALS:  nxt_rdata = 32'(dec_ff);
				`PPC_A_UNIT:      nxt_rdata = 32'(unit_ff);
				`PPC_A_PLS_SCALE: nxt_rdata = 32'(pscl_ff);
				`PPC_A_PLS_FILT:  nxt_rdata = 32'(pflt_ff);
				`PPC_A_INT_STAT:  nxt_rdata = 32'(stat_ff);
				`PPC_A_INT_EN:    nxt_rdata = 32'(ien_ff);
				`PPC_A_DISPLAY:   nxt_rdata = {8'h0, unit_ff, dec_ff,
					2'h0, disp};
				`PPC_A_OUT_PCT:   nxt_rdata = 32'(fout_ff);
				`PPC_A_TGT_PCT:   nxt_rdata = 32'(target);
				default:          nxt_rdata = '0;
			endcase
		end
		// Only the two analog sources can collide
		nxt_alarm = (tsrc_ff == 3'(fsrc_ff)) &&
			(fsrc_ff == 2'h1 || fsrc_ff == 2'h2);
		nxt_run_d = run;
		nxt_base  = (run && !run_d_ff) ? freq_cmd_pct : base_ff;
		nxt_scnt  = (scnt_ff >= 32'(SAMPLE_CYC - 1)) ? '0 : scnt_ff + 1;
		// Pulse gate: count edges, convert, then low-pass
		nxt_pin_d  = pulse_in;
		nxt_pcnt   = pcnt_ff + 32'(pulse_in && !pin_d_ff);
		nxt_gcnt   = gcnt_ff + 1;
		nxt_pflt_v = pflt_v_ff;
		hz  = pcnt_ff * (`PPC_MS_PER_S / `PPC_GATE_MS);
		pct = (pscl_ff == 16'h0000) ? 32'(`PPC_PCT_FULL) :
			(hz * `PPC_PCT_FULL) / 32'(pscl_ff);
		if (pct > `PPC_PCT_FULL)
			pct = `PPC_PCT_FULL;
		if (gcnt_ff >= 32'(GATE_CYC - 1))
		begin
			nxt_gcnt   = '0;
			nxt_pcnt   = '0;
			nxt_pflt_v = 14'(32'(pflt_v_ff) +
				32'($signed(pct - 32'(pflt_v_ff)) >>> pflt_ff));
		end
		// Bypass passes the command straight through
		nxt_fout = mode_ff[`PPC_M_EN] ? cif.out_pct : freq_cmd_pct;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tsrc_ff   <= `PPC_R_TGT_SRC;
			fsrc_ff   <= `PPC_R_FB_SRC;
			store_ff  <= '0;
			mode_ff   <= '0;
			fbg_ff    <= `PPC_R_FB_GAIN;
			kp_ff     <= `PPC_R_KP;
			ti_ff     <= `PPC_R_TI;
			td_ff     <= '0;
			msel_ff   <= '0;
			fbmax_ff  <= `PPC_R_FB_MAX;
			dec_ff    <= `PPC_R_DECIMALS;
			unit_ff   <= '0;
			pscl_ff   <= `PPC_R_PLS_SCALE;
			pflt_ff   <= '0;
			stat_ff   <= '0;
			ien_ff    <= '0;
			rdata_ff  <= '0;
			alarm_ff  <= 1'b0;
			fout_ff   <= '0;
			base_ff   <= '0;
			run_d_ff  <= 1'b0;
			scnt_ff   <= '0;
			gcnt_ff   <= '0;
			pcnt_ff   <= '0;
			pin_d_ff  <= 1'b0;
			pflt_v_ff <= '0;
		end
		else
		begin
			tsrc_ff   <= nxt_tsrc;
			fsrc_ff   <= nxt_fsrc;
			store_ff  <= nxt_store;
			mode_ff   <= nxt_mode;
			fbg_ff    <= nxt_fbg;
			kp_ff     <= nxt_kp;
			ti_ff     <= nxt_ti;
			td_ff     <= nxt_td;
			msel_ff   <= nxt_msel;
			fbmax_ff  <= nxt_fbmax;
			dec_ff    <= nxt_dec;
			unit_ff   <= nxt_unit;
			pscl_ff   <= nxt_pscl;
			pflt_ff   <= nxt_pflt;
			stat_ff   <= nxt_stat;
			ien_ff    <= nxt_ien;
			rdata_ff  <= nxt_rdata;
			alarm_ff  <= nxt_alarm;
			fout_ff   <= nxt_fout;
			base_ff   <= nxt_base;
			run_d_ff  <= nxt_run_d;
			scnt_ff   <= nxt_scnt;
			gcnt_ff   <= nxt_gcnt;
			pcnt_ff   <= nxt_pcnt;
			pin_d_ff  <= nxt_pin_d;
			pflt_v_ff <= nxt_pflt_v;
		end
	end

	// ----------------------------------------
	// Core hookup
	// ----------------------------------------
	assign cif.run_en    = mode_ff[`PPC_M_EN] & run;
	assign cif.sample_en = (scnt_ff == '0);
	assign cif.mode      = mode_ff;
	assign cif.kp        = kp_ff;
	assign cif.ti        = ti_ff;
	assign cif.td        = td_ff;
	assign cif.fb_gain   = fbg_ff;
	assign cif.target    = target;
	assign cif.fb_raw    = fb_raw;
	assign cif.base      = base_ff;

	ppc_pid_core u_core
	(
		.clk  (clk),
		.rstn (rstn),
		.cif  (cif)
	);

	assign rdata                    = rdata_ff;
	assign freq_out_pct             = fout_ff;
	assign same_source_config_alarm = alarm_ff;
	assign irq                      = |(stat_ff & ien_ff);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	alarm_same_src_a: assert property ((tsrc_ff == 3'h1 && fsrc_ff == 2'h1)
		|=> same_source_config_alarm) else $error("alarm missing");
	bypass_pass_a: assert property (!mode_ff[`PPC_M_EN] && $stable(mode_ff)
		|=> freq_out_pct == $past(freq_cmd_pct))
		else $error("bypass output wrong");
	out_clamp_a: assert property (freq_out_pct <= 14'h2710)
		else $error("output above full scale");
	stat_clear_a: assert property (wr && addr == `PPC_A_INT_CLR &&
		wdata[0] && !ev[`PPC_I_ALARM] |=> !stat_ff[0])
		else $error("status clear ignored");
	stat_sticky_a: assert property (stat_ff[0] && !(wr &&
		addr == `PPC_A_INT_CLR && wdata[0]) |=> stat_ff[0])
		else $error("status bit lost");
	tgt_gate_a: assert property (msel_ff != `PPC_MAIN_SEL_PID
		|-> target == store_ff) else $error("selector not gated");
	tgt_ana_a: assert property (msel_ff == `PPC_MAIN_SEL_PID &&
		tsrc_ff == 3'h1 && first_analog_input == '1 |-> target == 14'h2710)
		else $error("analog span wrong");
	base_capture_a: assert property ($rose(run) |=> ##1
		base_ff == $past(freq_cmd_pct, 2)) else $error("base missed");
	disp_limit_a: assert property (disp <= fbmax_ff)
		else $error("display over max");

endmodule

// [hdl/ppc_cfg.svh]
// Purpose: Offsets, field positions, reset values, timing counts
// Assumes: 20 MHz clock, percent values in 0.01 % steps
// Notes:   Included by the regulator top and core
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PPC_A_TGT_SRC    8'h00
`define PPC_A_FB_SRC     8'h04
`define PPC_A_TGT_STORE  8'h08
`define PPC_A_MODE       8'h0c
`define PPC_A_FB_GAIN    8'h10
`define PPC_A_KP         8'h14
`define PPC_A_TI         8'h18
`define PPC_A_TD         8'h1c
`define PPC_A_MAIN_SEL   8'h20
`define PPC_A_FB_MAX     8'h24
`define PPC_A_DECIMALS   8'h28
`define PPC_A_UNIT       8'h2c
`define PPC_A_PLS_SCALE  8'h30
`define PPC_A_PLS_FILT   8'h34
`define PPC_A_INT_STAT   8'h38
`define PPC_A_INT_CLR    8'h3c
`define PPC_A_INT_EN     8'h40
`define PPC_A_DISPLAY    8'h44
`define PPC_A_OUT_PCT    8'h48
`define PPC_A_TGT_PCT    8'h4c

// ----------------------------------------
// Mode word bits
// ----------------------------------------
`define PPC_M_EN         0
`define PPC_M_REV        1
`define PPC_M_DFB        2
`define PPC_M_ADD        3

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define PPC_I_ALARM      0
`define PPC_I_CLAMP      1

// ----------------------------------------
// Reset values and scaling
// ----------------------------------------
`define PPC_R_TGT_SRC    3'h4
`define PPC_R_FB_SRC     2'h1
`define PPC_R_FB_GAIN    10'h064
`define PPC_R_KP         10'h064
`define PPC_R_TI         10'h00a
`define PPC_R_FB_MAX     16'h03e8
`define PPC_R_DECIMALS   4'h1
`define PPC_R_PLS_SCALE  16'h03e8
`define PPC_MAIN_SEL_PID 3'h5
`define PPC_PCT_FULL     10000
`define PPC_GAIN_ONE     100
`define PPC_SUM_LIM      1000000

// ----------------------------------------
// Timing
// ----------------------------------------
`define PPC_CLK_NS       50
`define PPC_SAMPLE_NS    1000000
`define PPC_GATE_MS      100
`define PPC_MS_PER_S     1000
`define PPC_TI_MS        100
`define PPC_TD_PER_TS    10

`endif

// [hdl/ppc_pkg.sv]
// Purpose: Shared types of the process regulator
// Assumes: Constants come from ppc_cfg.svh
// Notes:   Nothing is imported; users write ppc_pkg::name
package ppc_pkg;

	typedef logic [13:0] ppc_pct_t;

	typedef enum logic [2:0]
	{
		PPC_TS_NONE,
		PPC_TS_AI1,
		PPC_TS_AI2,
		PPC_TS_PULSE,
		PPC_TS_STORED,
		PPC_TS_RSVD,
		PPC_TS_FCMD
	} ppc_tsrc_t;

endpackage

// [hdl/ppc_core_if.sv]
// Purpose: Settings and results between regulator top and core
// Assumes: One clock domain
// Notes:   Top drives settings, core returns output
`timescale 1ns/1ps
interface ppc_core_if;
	logic                   run_en;
	logic                   sample_en;
	logic [3:0]             mode;
	logic [9:0]             kp;
	logic [9:0]             ti;
	logic [9:0]             td;
	logic [9:0]             fb_gain;
	ppc_pkg::ppc_pct_t      target;
	ppc_pkg::ppc_pct_t      fb_raw;
	ppc_pkg::ppc_pct_t      base;
	ppc_pkg::ppc_pct_t      out_pct;
	logic                   clamp_hit;

	modport top
	(
		output run_en, sample_en, mode, kp, ti, td, fb_gain,
		output target, fb_raw, base,
		input  out_pct, clamp_hit
	);
	modport core
	(
		input  run_en, sample_en, mode, kp, ti, td, fb_gain,
		input  target, fb_raw, base,
		output out_pct, clamp_hit
	);
endinterface

// [hdl/ppc_pid_core.sv]
// Purpose: Sampled PID arithmetic with clamp
// Assumes: One sample per sample_en pulse, 1 ms apart
// Notes:   Integrator and history cleared while not running
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_pid_core
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Settings and result
	ppc_core_if.core  cif
);

	logic signed [31:0] integ_ff, nxt_integ;
	logic signed [31:0] prev_ff,  nxt_prev;
	logic [13:0]        out_ff,   nxt_out;
	logic               clamp_ff, nxt_clamp;

	// ----------------------------------------
	// Regulator arithmetic
	// ----------------------------------------
	always_comb
	begin
		logic signed [31:0] fb, err, dsrc, iterm, dterm, sum, u, lim;
		fb    = ($signed({18'h0, cif.fb_raw}) *
			$signed({22'h0, cif.fb_gain})) / `PPC_GAIN_ONE;
		err   = $signed({18'h0, cif.target}) - fb;
		if (cif.mode[`PPC_M_REV])
			err = -err;
		dsrc  = cif.mode[`PPC_M_DFB] ? -fb : err;
		lim   = $signed({22'h0, cif.ti}) * `PPC_SUM_LIM;
		nxt_integ = integ_ff;
		nxt_prev  = prev_ff;
		nxt_out   = out_ff;
		nxt_clamp = 1'b0;
		if (!cif.run_en)
		begin
			nxt_integ = '0;
			nxt_prev  = '0;
			nxt_out   = '0;
		end
		else if (cif.sample_en)
		begin
			// Windup bounded so the integral term stays within 100 %
			nxt_integ = (cif.ti == 10'h000) ? 32'sh0 : integ_ff + err;
			if (nxt_integ > lim)
				nxt_integ = lim;
			if (nxt_integ < -lim)
				nxt_integ = -lim;
			nxt_prev = dsrc;
		end
		iterm = (cif.ti == 10'h000) ? 32'sh0 :
			nxt_integ / ($signed({22'h0, cif.ti}) * `PPC_TI_MS);
		dterm = (dsrc - prev_ff) * $signed({22'h0, cif.td}) *
			`PPC_TD_PER_TS;
		sum   = err + iterm + dterm;
		if (sum > `PPC_SUM_LIM)
			sum = `PPC_SUM_LIM;
		if (sum < -`PPC_SUM_LIM)
			sum = -`PPC_SUM_LIM;
		u = (sum * $signed({22'h0, cif.kp})) / `PPC_GAIN_ONE;
		if (cif.mode[`PPC_M_ADD])
			u = u + $signed({18'h0, cif.base});
		if (cif.run_en && cif.sample_en)
		begin
			if (u < 0)
			begin
				nxt_out   = '0;
				nxt_clamp = 1'b1;
			end
			else if (u > `PPC_PCT_FULL)
			begin
				nxt_out   = 14'(`PPC_PCT_FULL);
				nxt_clamp = 1'b1;
			end
			else
				nxt_out = u[13:0];
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			integ_ff <= '0;
			prev_ff  <= '0;
			out_ff   <= '0;
			clamp_ff <= 1'b0;
		end
		else
		begin
			integ_ff <= nxt_integ;
			prev_ff  <= nxt_prev;
			out_ff   <= nxt_out;
			clamp_ff <= nxt_clamp;
		end
	end

	assign cif.out_pct   = out_ff;
	assign cif.clamp_hit = clamp_ff;

endmodule

// [tb/ppc_far_side.sv]
// Purpose: Far side model: analog front ends and pulse source
// Assumes: Requests change right after a rising clk edge
// Notes:   Pulse line idles low while no burst is asked for
`timescale 1ns/1ps
module ppc_far_side
#(
	parameter int AI_W = 12
)
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rstn,
	// Requested levels
	input  wire logic [AI_W-1:0] ai1_req,
	input  wire logic [AI_W-1:0] ai2_req,
	input  wire logic [7:0]      half,
	// Lines into the regulator
	output logic      [AI_W-1:0] ai1,
	output logic      [AI_W-1:0] ai2,
	output logic                 pulse
);
	logic [7:0] cnt;

	// Converters deliver one settled code per clock
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ai1   <= '0;
			ai2   <= '0;
			pulse <= 1'h0;
			cnt   <= 8'h0;
		end
		else
		begin
			ai1 <= ai1_req;
			ai2 <= ai2_req;
			if (half == 8'h0)
			begin
				pulse <= 1'h0;
				cnt   <= 8'h0;
			end
			else if (cnt + 8'h1 >= half)
			begin
				pulse <= ~pulse;
				cnt   <= 8'h0;
			end
			else
				cnt <= cnt + 8'h1;
		end
	end
endmodule

// [tb/tb_process_pid_setpoint_control.sv]
// Purpose: Self-checking bench for the process regulator
// Assumes: Short sample and gate periods keep the run brief
// Notes:   Register dump expectations come from the bench register model; other reads are checked against fixed values
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module tb_process_pid_setpoint_control;
	localparam int SC = 16;
	logic        clk, rstn, wr, rd, pulse, run, alarm, irq;
	logic [7:0]  addr, half;
	logic [31:0] wdata, rdata, v;
	logic [11:0] ai1, ai2, ai1_q, ai2_q;
	logic [13:0] cmd, fout, prev;
	logic [16:0] lf;
	logic [31:0] mdl [0:20];
	int          fail_count, tests_run;

	ppc_pid_top #(.SAMPLE_CYC(SC), .GATE_CYC(400)) dut (.clk(clk),
		.rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .first_analog_input(ai1_q),
		.second_analog_input(ai2_q), .pulse_in(pulse),
		.freq_cmd_pct(cmd), .run(run), .freq_out_pct(fout),
		.same_source_config_alarm(alarm), .irq(irq));
	ppc_far_side fs (.clk(clk), .rstn(rstn), .ai1_req(ai1),
		.ai2_req(ai2), .half(half), .ai1(ai1_q), .ai2(ai2_q),
		.pulse(pulse));

	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [16:0] nx(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr    <= 1'h1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
		if (a <= 8'h34 || a == 8'h40)
			mdl[a[6:2]] = d;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		rd   <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 v = rdata;
	endtask
	task automatic regs(input int n);
		for (int a = 0; a < n; a++)
		begin
			rreg(8'(a * 4));
			chk(v, mdl[a]);
		end
	endtask
	task automatic tgt(input logic [31:0] e);
		repeat (4) @(posedge clk);
		rreg(`PPC_A_TGT_PCT);
		chk(v, e);
	endtask
	// Bounded: a sample period is SC cycles
	task automatic wait_out(input logic [13:0] e);
		int n;
		n = 0;
		while (fout !== e && n < 30 * SC)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk(32'(fout), 32'(e));
	endtask
	// Bounded: first nonzero output after a run start
	task automatic first_nz(input logic [13:0] e);
		int n;
		n = 0;
		while (fout === 14'h0 && n < 30 * SC)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk(32'(fout), 32'(e));
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		rstn = 1'h0;
		{wr, rd, run, addr, wdata, cmd, ai1, ai2, half} = '0;
		lf = 17'h16ee4;
		fail_count = 0;
		tests_run = 0;
		foreach (mdl[i])
			mdl[i] = 32'h0;
		mdl[0]  = 32'(`PPC_R_TGT_SRC);
		mdl[1]  = 32'(`PPC_R_FB_SRC);
		mdl[4]  = 32'(`PPC_R_FB_GAIN);
		mdl[5]  = 32'(`PPC_R_KP);
		mdl[6]  = 32'(`PPC_R_TI);
		mdl[9]  = 32'(`PPC_R_FB_MAX);
		mdl[10] = 32'(`PPC_R_DECIMALS);
		mdl[12] = 32'(`PPC_R_PLS_SCALE);
		mdl[17] = 32'h0001_0000;
		repeat (20) @(posedge clk);
		rstn <= 1'h1;
		regs(21);
		$display("test reset done");
		half <= 8'h0;
		wreg(`PPC_A_FB_SRC, 32'h2);
		wreg(`PPC_A_TGT_STORE, 32'h9c4);
		wreg(`PPC_A_TGT_SRC, 32'h1);
		ai1 <= 12'hfff;
		tgt(32'h9c4);
		wreg(`PPC_A_MAIN_SEL, 32'h5);
		tgt(32'h2710);
		wreg(`PPC_A_INT_EN, 32'h0);
		ai1 <= 12'h0;
		tgt(32'h0);
		wreg(`PPC_A_TGT_SRC, 32'h4);
		tgt(32'h9c4);
		wreg(`PPC_A_TGT_SRC, 32'h6);
		cmd <= 14'hd05;
		tgt(32'hd05);
		wreg(`PPC_A_FB_SRC, 32'h1);
		wreg(`PPC_A_TGT_SRC, 32'h2);
		ai2 <= 12'hfff;
		tgt(32'h2710);
		wreg(`PPC_A_TGT_SRC, 32'h3);
		repeat (900) @(posedge clk);
		tgt(32'h0);
		$display("test target done");
		wreg(`PPC_A_TGT_SRC, 32'h1);
		repeat (2) @(posedge clk);
		#1 chk(32'(alarm), 32'h1);
		chk(32'(irq), 32'h0);
		rreg(`PPC_A_INT_STAT);
		chk(v & 32'h1, 32'h1);
		wreg(`PPC_A_INT_EN, 32'h3);
		repeat (2) @(posedge clk);
		#1 chk(32'(irq), 32'h1);
		wreg(`PPC_A_INT_CLR, 32'h1);
		repeat (2) @(posedge clk);
		#1 chk(32'(irq), 32'h0);
		wreg(`PPC_A_FB_SRC, 32'h2);
		repeat (2) @(posedge clk);
		#1 chk(32'(alarm), 32'h0);
		$display("test alarm done");
		half <= 8'h5;
		for (int k = 0; k < 40; k++)
		begin
			@(posedge clk);
			lf = nx(lf);
			cmd <= 14'(lf % 17'd10001);
			#1 if (k > 0) chk(32'(fout), 32'(prev));
			prev = cmd;
		end
		$display("test bypass done");
		wreg(`PPC_A_TGT_SRC, 32'h4);
		wreg(`PPC_A_TGT_STORE, 32'h2710);
		wreg(`PPC_A_KP, 32'h3e8);
		wreg(`PPC_A_TI, 32'h0);
		ai2 <= 12'h0;
		wreg(`PPC_A_MODE, 32'h1);
		run <= 1'h1;
		wait_out(14'h2710);
		rreg(`PPC_A_INT_STAT);
		chk(v & 32'h2, 32'h2);
		chk(32'(irq), 32'h1);
		wreg(`PPC_A_MODE, 32'h3);
		wait_out(14'h0);
		wreg(`PPC_A_KP, 32'h64);
		wreg(`PPC_A_TGT_STORE, 32'h1d4c);
		wreg(`PPC_A_FB_GAIN, 32'h32);
		ai2 <= 12'hfff;
		wreg(`PPC_A_MODE, 32'h1);
		wait_out(14'h9c4);
		run <= 1'h0;
		wait_out(14'h0);
		$display("test regulate done");
		wreg(`PPC_A_TGT_STORE, 32'h0);
		ai2 <= 12'h0;
		cmd <= 14'hfa0;
		wreg(`PPC_A_MODE, 32'h9);
		run <= 1'h1;
		wait_out(14'hfa0);
		@(posedge clk);
		cmd <= 14'h3e8;
		repeat (3 * SC) @(posedge clk);
		#1 chk(32'(fout), 32'hfa0);
		@(posedge clk);
		run <= 1'h0;
		$display("test add done");
		wreg(`PPC_A_TGT_STORE, 32'h1d4c);
		wreg(`PPC_A_TD, 32'h1);
		ai2 <= 12'hfff;
		wreg(`PPC_A_MODE, 32'h1);
		run <= 1'h1;
		wait_out(14'h2710);
		wait_out(14'h9c4);
		run <= 1'h0;
		wait_out(14'h0);
		wreg(`PPC_A_MODE, 32'h5);
		run <= 1'h1;
		first_nz(14'h9c4);
		run <= 1'h0;
		$display("test derivative done");
		wreg(`PPC_A_UNIT, 32'h3);
		wreg(`PPC_A_TGT_STORE, 32'h3e8);
		rreg(`PPC_A_DISPLAY);
		chk(v, 32'h31_0064);
		wreg(`PPC_A_FB_MAX, 32'h3e7);
		wreg(`PPC_A_TGT_STORE, 32'h2710);
		wreg(`PPC_A_DISPLAY, 32'hffff);
		rreg(`PPC_A_DISPLAY);
		chk(v, 32'h31_03e7);
		regs(14);
		$display("test display done");
		close_out();
	end
endmodule
